// [inc/pdt_pkg.sv]
// Constants, register map and types of the dual reload down-timer.
package pdt_pkg;

   // ----------------------------------------------------------------
   // Bus geometry
   // ----------------------------------------------------------------
   localparam int         ADDR_W      = 18;
   localparam int         DATA_W      = 32;
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ----------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_T0_MODE  = 16'hffc0;
   localparam logic [15:0] IDX_OUT_CTL  = 16'hffc1;
   localparam logic [15:0] IDX_RUN    [2] = '{16'hffc2, 16'hffc3};
   localparam logic [15:0] IDX_RLD_LO [2] = '{16'hffc4, 16'hffc6};
   localparam logic [15:0] IDX_RLD_HI [2] = '{16'hffc5, 16'hffc7};
   localparam logic [15:0] IDX_CNT_LO [2] = '{16'hffc8, 16'hffca};
   localparam logic [15:0] IDX_CNT_HI [2] = '{16'hffc9, 16'hffcb};
   localparam logic [15:0] IDX_IRQ_EN   = 16'hffe2;
   localparam logic [15:0] IDX_IRQ_FLAG = 16'hfff2;

   // ----------------------------------------------------------------
   // Field positions and reset values
   // ----------------------------------------------------------------
   localparam int MODE_POL_BIT  = 0;
   localparam int MODE_FILT_BIT = 1;
   localparam int MODE_EVT_BIT  = 2;
   localparam int OUT_SRC_LSB   = 0;
   localparam int OUT_GATE_BIT  = 2;
   localparam int OUT_OUTPUT_CHANNEL_SELECT_BIT = 3;
   localparam int RUN_BIT       = 0;
   localparam int RELOAD_BIT    = 1;
   localparam int RATIO_LSB     = 2;
   localparam logic [3:0] NIB_RST  = 4'h0;
   localparam logic [7:0] BYTE_RST = 8'h00;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int LS_OSC_HZ     = 32768;
   localparam int FILTER_HZ     = 2048;
   localparam int STROBE_DIV    = LS_OSC_HZ / FILTER_HZ;
   localparam logic [3:0] STROBE_TC = 4'(STROBE_DIV - 1);
   localparam logic [1:0] FILTER_STROBES = 2'h2;
   // Prescaler terminal counts for divide by 1, 4, 32 and 256.
   localparam logic [7:0] PRE_TC [4] = '{8'h00, 8'h03, 8'h1f, 8'hff};

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      WS_IDLE = 2'b00,
      WS_ADDR = 2'b01,
      WS_DATA = 2'b10,
      WS_RESP = 2'b11
   } pdt_wr_state_t;

   function automatic logic is_mapped(input logic [15:0] idx);
      logic hit;
      hit = (idx == IDX_T0_MODE) || (idx == IDX_OUT_CTL) ||
            (idx == IDX_IRQ_EN) || (idx == IDX_IRQ_FLAG);
      for (int k = 0; k < 2; k++) begin
         hit = hit || (idx == IDX_RUN[k]) || (idx == IDX_RLD_LO[k]) ||
               (idx == IDX_RLD_HI[k]) || (idx == IDX_CNT_LO[k]) ||
               (idx == IDX_CNT_HI[k]);
      end
      return hit;
   endfunction : is_mapped

endpackage : pdt_pkg

// [inc/pdt_tmr_if.sv]
// Interface between the register block and one timer channel.
`timescale 1ns/100ps
interface pdt_tmr_if;
   logic       src_tick;
   logic       bypass;
   logic [1:0] ratio;
   logic [7:0] reload;
   logic       reload_req;
   logic       run_req;
   logic       running;
   logic [7:0] count;
   logic       underflow;

   modport ctl (
      output src_tick, bypass, ratio, reload, reload_req, run_req,
      input  running, count, underflow
   );
   modport core (
      input  src_tick, bypass, ratio, reload, reload_req, run_req,
      output running, count, underflow
   );
endinterface : pdt_tmr_if

// [logic/pdt_timer_core.sv]
// One prescaled 8-bit reloadable down-counter.
`timescale 1ns/100ps
module pdt_timer_core (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Control and status
   pdt_tmr_if.core  tif
);

   logic [7:0] pre_q;
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   logic       run_q;
   logic       uf_q;
   logic       uf_d;
   wire  [7:0] pre_tc = pdt_pkg::PRE_TC[tif.ratio];
   wire        pre_hit = (pre_q == pre_tc);
   // Bypass takes every source tick, so event edges skip the divider.
   wire        clk_en = tif.src_tick && (tif.bypass || pre_hit);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre_q <= pdt_pkg::BYTE_RST;
      end else if (tif.src_tick) begin
         pre_q <= pre_hit ? pdt_pkg::BYTE_RST : pre_q + 8'h01;
      end
   end

   // ----------------------------------------------------------------
   // Down-counter
   // ----------------------------------------------------------------
   always_comb begin
      cnt_d = cnt_q;
      uf_d  = 1'b0;
      if (clk_en && run_q) begin
         if (cnt_q == pdt_pkg::BYTE_RST) begin
            cnt_d = tif.reload;
            uf_d  = 1'b1;
         end else begin
            cnt_d = cnt_q - 8'h01;
         end
      end
      // A reload request overrides a decrement in the same cycle.
      if (tif.reload_req) begin
         cnt_d = tif.reload;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= pdt_pkg::BYTE_RST;
         run_q <= 1'b0;
         uf_q  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         uf_q  <= uf_d;
         if (clk_en) begin
            run_q <= tif.run_req;
         end
      end
   end

   assign tif.count     = cnt_q;
   assign tif.running   = run_q;
   assign tif.underflow = uf_q;

endmodule : pdt_timer_core

// [logic/pdt_top.sv]
// Dual reload down-timer with event input, pulse output, AXI4-Lite regs.
//
// Summary of operation
// - Mode bit 1 makes timer 0 count external events, 0 internal clock.
// - Filter accepts an input change at the second 2048 Hz strobe.
// - Without filter the pin drives timer 0; filter only in event mode.
// - Polarity 0 counts falling edges, 1 rising; ignored in timer mode.
// - Counters load reload value on reload request and on underflow.
// - Count reads as nibbles; low read freezes high; writes ignored.
// - Writing 1 to reload bit loads counter; bit reads 0.
// - Run bit 1 starts, 0 stops; stopped count is held.
// - Run or stop applies only at the next prescaled count clock edge.
// - Run bit reads 1 until the timer has really stopped.
// - Channel select picks timer 0 or timer 1 underflows for pulse.
// - Gate on drives pulse onto pin; off holds pin high.
// - Gating switches the pin asynchronously to the pulse phase.
// - Bits 0 and 1 enable each timer interrupt request.
// - Underflow sets flag regardless of mask; write 1 clears.
// - Reset clears all control bits, flags, reload and count.
// - Source bit picks slow or fast oscillator; ignored in event mode.
// - Ratio codes divide by 1, 4, 32, 256; ignored in event mode.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/100ps
module pdt_top (
   // Clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // AXI4-Lite write address and data
   input  wire logic [pdt_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic [2:0]                 s_axi_awprot,
   input  wire logic                       s_axi_awvalid,
   output wire logic                       s_axi_awready,
   input  wire logic [pdt_pkg::DATA_W-1:0] s_axi_wdata,
   input  wire logic [3:0]                 s_axi_wstrb,
   input  wire logic                       s_axi_wvalid,
   output wire logic                       s_axi_wready,
   // AXI4-Lite write response
   output wire logic [1:0]                 s_axi_bresp,
   output wire logic                       s_axi_bvalid,
   input  wire logic                       s_axi_bready,
   // AXI4-Lite read
   input  wire logic [pdt_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic [2:0]                 s_axi_arprot,
   input  wire logic                       s_axi_arvalid,
   output wire logic                       s_axi_arready,
   output logic      [pdt_pkg::DATA_W-1:0] s_axi_rdata,
   output logic      [1:0]                 s_axi_rresp,
   output logic                            s_axi_rvalid,
   input  wire logic                       s_axi_rready,
   // Oscillator ticks, one cycle per source clock falling edge
   input  wire logic                       low_speed_osc_tick,
   input  wire logic                       high_speed_osc_tick,
   // Event input and pulse output
   input  wire logic                       event_input_pin,
   output logic                            shared_output_pin,
   output logic                            timer_pulse_signal,
   // Interrupt requests to the interrupt controller
   output logic                            t0_irq_req,
   output logic                            t1_irq_req
);

   // ----------------------------------------------------------------
   // Control registers
   // ----------------------------------------------------------------
   logic       event_mode_select_q;
   logic       noise_filter_select_q;
   logic       event_edge_polarity_q;
   logic       output_channel_select_q;
   logic       pulse_output_gate_q;
   logic [1:0] src_sel_q;
   logic [1:0] run_bit_q;
   logic [1:0] ratio_q   [2];
   logic [7:0] reload_q  [2];
   logic [3:0] hold_hi_q [2];
   logic [1:0] irq_en_q;
   logic [1:0] irq_flag_q;
   logic [1:0] irq_flag_d;

   // ----------------------------------------------------------------
   // Write channel
   // ----------------------------------------------------------------
   pdt_pkg::pdt_wr_state_t    ws_q;
   logic [pdt_pkg::ADDR_W-1:0] awaddr_q;
   logic [3:0]                 wdata_q;
   logic                       wstrb_q;
   logic                       wr_do_q;
   logic [1:0]                 bresp_q;

   wire aw_take = s_axi_awvalid && s_axi_awready;
   wire w_take  = s_axi_wvalid && s_axi_wready;
   assign s_axi_awready = (ws_q == pdt_pkg::WS_IDLE) ||
                          (ws_q == pdt_pkg::WS_DATA);
   assign s_axi_wready  = (ws_q == pdt_pkg::WS_IDLE) ||
                          (ws_q == pdt_pkg::WS_ADDR);
   assign s_axi_bvalid  = (ws_q == pdt_pkg::WS_RESP);
   assign s_axi_bresp   = bresp_q;

   wire [15:0] wr_idx = awaddr_q[pdt_pkg::ADDR_W-1:2];
   wire        wr_en  = wr_do_q && wstrb_q;
   wire [15:0] aw_idx = aw_take ? s_axi_awaddr[pdt_pkg::ADDR_W-1:2] : wr_idx;
   wire        wr_ok  = pdt_pkg::is_mapped(aw_idx);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ws_q     <= pdt_pkg::WS_IDLE;
         awaddr_q <= '0;
         wdata_q  <= pdt_pkg::NIB_RST;
         wstrb_q  <= 1'b0;
         wr_do_q  <= 1'b0;
      end else begin
         wr_do_q <= 1'b0;
         if (aw_take) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (w_take) begin
            wdata_q <= s_axi_wdata[3:0];
            wstrb_q <= s_axi_wstrb[0];
         end
         case (ws_q)
            pdt_pkg::WS_IDLE: begin
               if (aw_take && w_take) begin
                  ws_q    <= pdt_pkg::WS_RESP;
                  wr_do_q <= 1'b1;
               end else if (aw_take) begin
                  ws_q <= pdt_pkg::WS_ADDR;
               end else if (w_take) begin
                  ws_q <= pdt_pkg::WS_DATA;
               end
            end
            pdt_pkg::WS_ADDR, pdt_pkg::WS_DATA: begin
               if (aw_take || w_take) begin
                  ws_q    <= pdt_pkg::WS_RESP;
                  wr_do_q <= 1'b1;
               end
            end
            pdt_pkg::WS_RESP: begin
               if (s_axi_bready) begin
                  ws_q <= pdt_pkg::WS_IDLE;
               end
            end
            default: ws_q <= pdt_pkg::WS_IDLE;
         endcase
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bresp_q <= pdt_pkg::RESP_OKAY;
      end else if (aw_take || w_take) begin
         bresp_q <= wr_ok ? pdt_pkg::RESP_OKAY : pdt_pkg::RESP_SLVERR;
      end
   end

   // ----------------------------------------------------------------
   // Write decode
   // ----------------------------------------------------------------
   wire wr_mode  = wr_en && (wr_idx == pdt_pkg::IDX_T0_MODE);
   wire wr_out   = wr_en && (wr_idx == pdt_pkg::IDX_OUT_CTL);
   wire wr_irqen = wr_en && (wr_idx == pdt_pkg::IDX_IRQ_EN);
   wire wr_flag  = wr_en && (wr_idx == pdt_pkg::IDX_IRQ_FLAG);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         event_mode_select_q   <= 1'b0;
         noise_filter_select_q <= 1'b0;
         event_edge_polarity_q <= 1'b0;
      end else if (wr_mode) begin
         event_mode_select_q   <= wdata_q[pdt_pkg::MODE_EVT_BIT];
         noise_filter_select_q <= wdata_q[pdt_pkg::MODE_FILT_BIT];
         event_edge_polarity_q <= wdata_q[pdt_pkg::MODE_POL_BIT];
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         output_channel_select_q <= 1'b0;
         pulse_output_gate_q     <= 1'b0;
         src_sel_q               <= 2'b00;
         irq_en_q                <= 2'b00;
      end else begin
         if (wr_out) begin
            output_channel_select_q <= wdata_q[pdt_pkg::OUT_OUTPUT_CHANNEL_SELECT_BIT];
            pulse_output_gate_q     <= wdata_q[pdt_pkg::OUT_GATE_BIT];
            src_sel_q <= wdata_q[pdt_pkg::OUT_SRC_LSB +: 2];
         end
         if (wr_irqen) begin
            irq_en_q <= wdata_q[1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // Event input path for timer 0
   // ----------------------------------------------------------------
   logic       pin_q;
   logic       acc_q;
   logic [1:0] flt_cnt_q;
   logic [3:0] strobe_div_q;
   logic       lvl_prev_q;

   wire strobe = low_speed_osc_tick &&
                 (strobe_div_q == pdt_pkg::STROBE_TC);
   wire flt_last = (flt_cnt_q == pdt_pkg::FILTER_STROBES - 2'h1);
   wire evt_lvl  = noise_filter_select_q ? acc_q : pin_q;
   wire evt_rise = evt_lvl && !lvl_prev_q;
   wire evt_fall = !evt_lvl && lvl_prev_q;
   wire evt_tick = event_edge_polarity_q ? evt_rise : evt_fall;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_q        <= 1'b0;
         acc_q        <= 1'b0;
         flt_cnt_q    <= 2'b00;
         strobe_div_q <= 4'h0;
         lvl_prev_q   <= 1'b0;
      end else begin
         pin_q      <= event_input_pin;
         lvl_prev_q <= evt_lvl;
         if (low_speed_osc_tick) begin
            strobe_div_q <= strobe ? 4'h0 : strobe_div_q + 4'h1;
         end
         // A level that reverts before the second strobe is rejected.
         if (pin_q == acc_q) begin
            flt_cnt_q <= 2'b00;
         end else if (strobe) begin
            if (flt_last) begin
               acc_q     <= pin_q;
               flt_cnt_q <= 2'b00;
            end else begin
               flt_cnt_q <= flt_cnt_q + 2'h1;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Timer channels
   // ----------------------------------------------------------------
   pdt_tmr_if tif [2] ();
   logic [1:0] uf;
   logic [1:0] running;
   logic [7:0] count [2];

   genvar i;
   generate
      for (i = 0; i < 2; i++) begin : g_tmr
         wire is_evt = (i == 0) && event_mode_select_q;
         wire os_tick = src_sel_q[i] ? high_speed_osc_tick
                                     : low_speed_osc_tick;
         wire wr_run = wr_en && (wr_idx == pdt_pkg::IDX_RUN[i]);
         wire wr_rlo = wr_en && (wr_idx == pdt_pkg::IDX_RLD_LO[i]);
         wire wr_rhi = wr_en && (wr_idx == pdt_pkg::IDX_RLD_HI[i]);

         assign tif[i].src_tick   = is_evt ? evt_tick : os_tick;
         assign tif[i].bypass     = is_evt;
         assign tif[i].ratio      = ratio_q[i];
         assign tif[i].reload     = reload_q[i];
         assign tif[i].reload_req =
            wr_run && wdata_q[pdt_pkg::RELOAD_BIT];
         assign tif[i].run_req    = run_bit_q[i];
         assign uf[i]      = tif[i].underflow;
         assign running[i] = tif[i].running;
         assign count[i]   = tif[i].count;

         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               run_bit_q[i] <= 1'b0;
               ratio_q[i]   <= 2'b00;
               reload_q[i]  <= pdt_pkg::BYTE_RST;
            end else begin
               if (wr_run) begin
                  run_bit_q[i] <= wdata_q[pdt_pkg::RUN_BIT];
                  ratio_q[i]   <= wdata_q[pdt_pkg::RATIO_LSB +: 2];
               end
               if (wr_rlo) begin
                  reload_q[i][3:0] <= wdata_q;
               end
               if (wr_rhi) begin
                  reload_q[i][7:4] <= wdata_q;
               end
            end
         end

         pdt_timer_core u_core (
            .aclk    (aclk),
            .aresetn (aresetn),
            .tif     (tif[i])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Interrupt flags and pulse output
   // ----------------------------------------------------------------
   logic tpulse_q;

   // Set wins over a clear written in the same cycle.
   assign irq_flag_d = (irq_flag_q & ~({2{wr_flag}} & wdata_q[1:0]))
                       | uf;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_flag_q         <= 2'b00;
         tpulse_q           <= 1'b0;
         timer_pulse_signal <= 1'b0;
         shared_output_pin  <= 1'b1;
         t0_irq_req         <= 1'b0;
         t1_irq_req         <= 1'b0;
      end else begin
         irq_flag_q <= irq_flag_d;
         if (uf[output_channel_select_q]) begin
            tpulse_q <= !tpulse_q;
         end
         timer_pulse_signal <= tpulse_q;
         // The gate is not aligned to the pulse phase, so a short first
         // or last low period can appear when it is switched.
         shared_output_pin  <= pulse_output_gate_q ? tpulse_q
                                                   : 1'b1;
         t0_irq_req <= irq_flag_q[0] && irq_en_q[0];
         t1_irq_req <= irq_flag_q[1] && irq_en_q[1];
      end
   end

   // ----------------------------------------------------------------
   // Read channel
   // ----------------------------------------------------------------
   wire [15:0] rd_idx  = s_axi_araddr[pdt_pkg::ADDR_W-1:2];
   wire        ar_take = s_axi_arvalid && s_axi_arready;
   logic [3:0] rd_nib;

   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      rd_nib = pdt_pkg::NIB_RST;
      if (rd_idx == pdt_pkg::IDX_T0_MODE) begin
         rd_nib = {1'b0, event_mode_select_q, noise_filter_select_q,
                   event_edge_polarity_q};
      end
      if (rd_idx == pdt_pkg::IDX_OUT_CTL) begin
         rd_nib = {output_channel_select_q, pulse_output_gate_q,
                   src_sel_q};
      end
      if (rd_idx == pdt_pkg::IDX_IRQ_EN) begin
         rd_nib = {2'b00, irq_en_q};
      end
      if (rd_idx == pdt_pkg::IDX_IRQ_FLAG) begin
         rd_nib = {2'b00, irq_flag_q};
      end
      for (int k = 0; k < 2; k++) begin
         if (rd_idx == pdt_pkg::IDX_RUN[k]) begin
            rd_nib = {ratio_q[k], 1'b0,
                      run_bit_q[k] || running[k]};
         end
         if (rd_idx == pdt_pkg::IDX_RLD_LO[k]) begin
            rd_nib = reload_q[k][3:0];
         end
         if (rd_idx == pdt_pkg::IDX_RLD_HI[k]) begin
            rd_nib = reload_q[k][7:4];
         end
         if (rd_idx == pdt_pkg::IDX_CNT_LO[k]) begin
            rd_nib = count[k][3:0];
         end
         if (rd_idx == pdt_pkg::IDX_CNT_HI[k]) begin
            rd_nib = hold_hi_q[k];
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= pdt_pkg::RESP_OKAY;
         hold_hi_q    <= '{default: pdt_pkg::NIB_RST};
      end else begin
         if (ar_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {28'h0000000, rd_nib};
            s_axi_rresp  <= pdt_pkg::is_mapped(rd_idx) ?
                            pdt_pkg::RESP_OKAY : pdt_pkg::RESP_SLVERR;
            for (int k = 0; k < 2; k++) begin
               if (rd_idx == pdt_pkg::IDX_CNT_LO[k]) begin
                  hold_hi_q[k] <= count[k][7:4];
               end
            end
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

endmodule : pdt_top

// [testbench/pdt_sva.sv]
// Port-level timing checks for the dual reload down-timer.
`timescale 1ns/100ps
module pdt_sva (
   // Clock and reset
   input logic        aclk,
   input logic        aresetn,
   // Register bus
   input logic        s_axi_awvalid,
   input logic        s_axi_awready,
   input logic        s_axi_wvalid,
   input logic        s_axi_wready,
   input logic        s_axi_bvalid,
   input logic        s_axi_bready,
   input logic        s_axi_arvalid,
   input logic        s_axi_arready,
   input logic [31:0] s_axi_rdata,
   input logic        s_axi_rvalid,
   input logic        s_axi_rready,
   // Timer outputs
   input logic        shared_output_pin,
   input logic        timer_pulse_signal,
   input logic        t1_irq_req
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   AST_RST_OUT:
      assert property ($rose(aresetn) |-> shared_output_pin &&
         !timer_pulse_signal && !t1_irq_req) else $error("reset state");
   AST_PIN_GATE:
      assert property (!shared_output_pin |-> !timer_pulse_signal)
      else $error("pin low while pulse high");
   AST_RVALID:
      assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   AST_RHOLD:
      assert property (s_axi_rvalid && !s_axi_rready |=>
         s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata moved");
   AST_RNIB:
      assert property (s_axi_rvalid |-> s_axi_rdata[31:4] == 28'h0)
      else $error("upper read bits set");
   AST_BVALID:
      assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
         s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
   AST_BHOLD:
      assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   // The request only falls through a register write, which shows as bvalid.
   AST_IRQ_HOLD:
      assert property (t1_irq_req && !s_axi_bvalid && !$past(s_axi_bvalid)
         |=> t1_irq_req) else $error("request fell without a write");
endmodule : pdt_sva
bind pdt_top pdt_sva i_pdt_sva (.*);

// [testbench/pdt_evt_src.sv]
// Event pulse source in front of the event input pin.
`timescale 1ns/100ps
module pdt_evt_src (
   // Clock
   input  logic aclk,
   // Event line
   output logic event_input_pin
);
   // Idle high, so every pulse starts with a falling edge.
   initial event_input_pin = 1'b1;
   // Phases of four clocks outlast the pin sampling and edge detection.
   task automatic pulse(input int n);
      repeat (n) begin
         @(posedge aclk);
         event_input_pin <= 1'b0;
         repeat (4) @(posedge aclk);
         event_input_pin <= 1'b1;
         repeat (4) @(posedge aclk);
      end
   endtask : pulse
endmodule : pdt_evt_src

// [testbench/pdt_tb_top.sv]
// Register-level testbench of the dual reload down-timer.
`timescale 1ns/100ps
module pdt_tb_top;
   logic        aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic        s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic        low_speed_osc_tick = 0, high_speed_osc_tick = 0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic        s_axi_rvalid, shared_output_pin, timer_pulse_signal;
   logic        t0_irq_req, t1_irq_req, event_input_pin;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [2:0]  s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
   logic [3:0]  s_axi_wstrb = 4'hf;
   logic [17:0] s_axi_awaddr = 18'h0, s_axi_araddr = 18'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   int          num_errors = 0, checks_done = 0, cyc = 0;
   pdt_top i_pdt_top (.*);
   pdt_evt_src i_pdt_evt_src (.*);
   always #12.5 aclk = ~aclk;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [15:0] i, input logic [3:0] d,
                     input logic [1:0] r = 2'b00);
      logic a, w;
      a = 0;
      w = 0;
      @(posedge aclk);
      {s_axi_awaddr, s_axi_wdata} <= {i, 2'b00, 28'h0, d};
      {s_axi_awvalid, s_axi_wvalid} <= 2'b11;
      // Each channel is released only at the edge that took it.
      while (!(a && w)) begin
         @(negedge aclk);
         a = a | (s_axi_awready === 1'b1);
         w = w | (s_axi_wready === 1'b1);
         @(posedge aclk);
         {s_axi_awvalid, s_axi_wvalid} <= {!a, !w};
      end
      @(negedge aclk);
      while (s_axi_bvalid !== 1'b1) @(negedge aclk);
      chk(32'(s_axi_bresp), 32'(r));
      @(posedge aclk);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      s_axi_bready <= 1'b0;
      @(negedge aclk);
   endtask : wr
   task automatic rd(input logic [15:0] i, input logic [31:0] e,
                     input logic [1:0] r = 2'b00);
      logic [31:0] d;
      @(posedge aclk);
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      @(negedge aclk);
      while (s_axi_arready !== 1'b1) @(negedge aclk);
      @(posedge aclk);
      s_axi_arvalid <= 1'b0;
      @(negedge aclk);
      while (s_axi_rvalid !== 1'b1) @(negedge aclk);
      d = s_axi_rdata;
      chk(32'(s_axi_rresp), 32'(r));
      // A late rready makes the slave hold its answer for a cycle.
      @(posedge aclk);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      s_axi_rready <= 1'b0;
      chk(d, e);
      @(negedge aclk);
   endtask : rd
   task automatic tk(input int n);
      repeat (n) begin
         @(posedge aclk);
         low_speed_osc_tick <= 1'b1;
         @(posedge aclk);
         low_speed_osc_tick <= 1'b0;
         repeat (2) @(posedge aclk);
      end
   endtask : tk
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : end_of_test
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         num_errors++;
         end_of_test;
      end
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 12; i++) rd(16'hffc0 + 16'(i), 0);
      rd(16'hffe2, 0);
      rd(16'hfff2, 0);
      rd(16'hffd0, 0, 2'b10);
      wr(16'hffd0, 4'hf, 2'b10);
      $display("test reset done");
      wr(16'hffc1, 4'hc);
      wr(16'hffc6, 4'h3);
      wr(16'hffc3, 4'h2);
      rd(16'hffca, 3);
      rd(16'hffc3, 0);
      wr(16'hffc3, 4'h1);
      tk(4);
      rd(16'hffca, 0);
      chk(32'(shared_output_pin), 0);
      tk(1);
      rd(16'hffca, 3);
      chk(32'(timer_pulse_signal), 1);
      wr(16'hfff2, 4'h0);
      rd(16'hfff2, 2);
      chk(32'(t1_irq_req), 0);
      wr(16'hffe2, 4'h2);
      chk(32'(t1_irq_req), 1);
      wr(16'hfff2, 4'h2);
      rd(16'hfff2, 0);
      chk(32'(t1_irq_req), 0);
      $display("test timer 1 done");
      wr(16'hffc0, 4'h4);
      wr(16'hffc4, 4'h2);
      wr(16'hffc5, 4'h1);
      wr(16'hffc2, 4'h2);
      wr(16'hffc2, 4'h1);
      tk(3);
      i_pdt_evt_src.pulse(3);
      rd(16'hffc8, 0);
      wr(16'hffc2, 4'h0);
      rd(16'hffc2, 1);
      i_pdt_evt_src.pulse(1);
      rd(16'hffc9, 1);
      rd(16'hffc2, 0);
      i_pdt_evt_src.pulse(1);
      rd(16'hffc8, 4'hf);
      wr(16'hffc8, 4'h5);
      rd(16'hffc8, 4'hf);
      rd(16'hffc9, 0);
      wr(16'hffc0, 4'h5);
      wr(16'hffc2, 4'h1);
      i_pdt_evt_src.pulse(2);
      rd(16'hffc8, 4'he);
      wr(16'hffc1, 4'h4);
      i_pdt_evt_src.pulse(15);
      rd(16'hffc8, 4'h2);
      rd(16'hfff2, 1);
      chk(32'(timer_pulse_signal), 0);
      wr(16'hffe2, 4'h1);
      chk(32'(t0_irq_req), 1);
      wr(16'hffc0, 4'h7);
      tk(20);
      rd(16'hffc8, 4'h2);
      tk(4);
      rd(16'hffc8, 4'h1);
      $display("test timer 0 done");
      end_of_test;
   end
endmodule : pdt_tb_top
